// ===== src/bisr_top.sv
`timescale 1ns/1ps
`include "bisr_defs.svh"
// Read-only battery information responder.
module bisr_top #(
  parameter int NCELL = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_write_i,
  input wire logic byte_ready_i,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic byte_last_o,
  output logic cmd_done_o,
  output logic [2:0] err_code_o,
  output logic [7:0] flash_addr_o,
  input wire logic [7:0] flash_data_i,
  input wire logic front_end_check_fail_i,
  input wire logic [15:0] pack_voltage_i,
  input wire logic [15:0] cell_voltage_i,
  input wire logic use_cell_voltage_i,
  input wire logic [15:0] end_voltage_two_i,
  input wire logic [NCELL*16-1:0] cell_volts_i,
  input wire logic [15:0] cell_under_limit_i,
  input wire logic sealed_i,
  input wire logic discharge_qualified_i,
  input wire logic safety_overvoltage_i,
  input wire logic cell_over_voltage_i,
  input wire logic [7:0] gauge_cfg_i,
  input wire logic [7:0] misc_cfg_i,
  input wire logic [7:0] digital_filter_i,
  input wire logic [7:0] self_discharge_i,
  input wire logic [7:0] load_estimate_i,
  input wire logic [7:0] battery_low_i,
  input wire logic [15:0] near_full_i,
  input wire logic [7:0] front_end_status_i,
  input wire logic [15:0] pending_edv_i,
  output logic [7:0] pack_status_o
);
  bisr_pkg::bisr_state_t state_r;
  bisr_pkg::bisr_kind_t kind_r;
  logic [7:0] cmd_r;
  logic [7:0] base_r;
  logic [7:0] idx_r;
  logic [7:0] count_r;
  logic [7:0] max_r;
  logic front_end_r;
  logic end_voltage_two_flag;
  logic cell_under_voltage_flag;
  logic [NCELL-1:0] cell_low;
  logic [15:0] monitored;
  logic [7:0] mfg_byte;
  logic [7:0] send_byte;
  logic [7:0] pack_cfg_r;
  logic xfer;

  // Monitored voltage picked by the programming option.
  assign monitored = use_cell_voltage_i ? cell_voltage_i : pack_voltage_i;

  // End-voltage-two comparison, at or below.
  bisr_cmp #(.WIDTH(16)) u_edv (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .value_i(monitored),
    .limit_i(end_voltage_two_i),
    .below_only_i(1'b0),
    .hit_o(end_voltage_two_flag)
  );

  // One strict comparator per cell against the cell-under limit.
  genvar gi;
  generate
    for (gi = 0; gi < NCELL; gi++) begin : g_cell
      bisr_cmp #(.WIDTH(16)) u_cuv (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .value_i(cell_volts_i[gi*16 +: 16]),
        .limit_i(cell_under_limit_i),
        .below_only_i(1'b1),
        .hit_o(cell_low[gi])
      );
    end
  endgenerate
  assign cell_under_voltage_flag = |cell_low;

  // Front-end check result is held as a level.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      front_end_r <= 1'b0;
    end else if (ce_i) begin
      front_end_r <= front_end_check_fail_i;
    end
  end

  // Pack status byte assembly; bit 3 is always zero.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pack_status_o <= 8'h00;
    end else if (ce_i) begin
      pack_status_o[`BISR_ST_FRONT_END] <= front_end_r;
      pack_status_o[`BISR_ST_EDV_TWO] <= end_voltage_two_flag;
      pack_status_o[`BISR_ST_SEALED] <= sealed_i;
      pack_status_o[`BISR_ST_QUALIFIED] <= discharge_qualified_i;
      pack_status_o[`BISR_ST_ZERO] <= 1'b0;
      pack_status_o[`BISR_ST_SAFETY_OV] <= safety_overvoltage_i;
      pack_status_o[`BISR_ST_CELL_OV] <= cell_over_voltage_i;
      pack_status_o[`BISR_ST_CELL_UV] <= cell_under_voltage_flag;
    end
  end

  // Manufacturer data bytes in transmit order, after the length byte.
  always_comb begin
    case (count_r)
      8'h00: mfg_byte = pack_cfg_r;
      8'h01: mfg_byte = gauge_cfg_i;
      8'h02: mfg_byte = misc_cfg_i;
      8'h03: mfg_byte = digital_filter_i;
      8'h04: mfg_byte = self_discharge_i;
      8'h05: mfg_byte = load_estimate_i;
      8'h06: mfg_byte = battery_low_i;
      8'h07: mfg_byte = near_full_i[7:0];
      8'h08: mfg_byte = near_full_i[15:8];
      8'h09: mfg_byte = front_end_status_i;
      8'h0a: mfg_byte = pending_edv_i[7:0];
      8'h0b: mfg_byte = pending_edv_i[15:8];
      default: mfg_byte = 8'h00;
    endcase
  end

  // Byte presented to the bus in the send state.
  always_comb begin
    send_byte = flash_data_i;
    if (cmd_r == `BISR_CMD_MFG_DATA) begin
      send_byte = (idx_r == 8'h00) ? `BISR_MFG_DATA_LEN : mfg_byte;
    end else if (cmd_r == `BISR_CMD_PACK_STAT) begin
      send_byte = (idx_r == 8'h00) ? pack_status_o : flash_data_i;
    end else if (kind_r == bisr_pkg::BISR_KIND_BLOCK && idx_r == 8'h00) begin
      // Length byte is clipped to the string's maximum.
      send_byte = (flash_data_i > max_r) ? max_r : flash_data_i;
    end
  end

  assign xfer = ce_i && byte_valid_o && byte_ready_i;

  // Flash address follows the byte in flight; pack config for 0x2f high and for all of 0x23.
  always_comb begin
    if (cmd_r == `BISR_CMD_PACK_STAT) begin
      flash_addr_o = `BISR_FLASH_PACK_CFG;
    end else if (cmd_r == `BISR_CMD_MFG_DATA) begin
      flash_addr_o = `BISR_FLASH_PACK_CFG;
    end else if (kind_r == bisr_pkg::BISR_KIND_WORD) begin
      // Flash holds the high byte first; the bus wants the low byte first.
      flash_addr_o = base_r + ((idx_r == 8'h00) ? 8'h01 : 8'h00);
    end else begin
      flash_addr_o = base_r + idx_r;
    end
  end

  // Command decoder, fetch and byte sender.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= bisr_pkg::BISR_IDLE;
      kind_r <= bisr_pkg::BISR_KIND_NONE;
      cmd_r <= 8'h00;
      base_r <= 8'h00;
      idx_r <= 8'h00;
      count_r <= 8'h00;
      max_r <= 8'h00;
      pack_cfg_r <= 8'h00;
      byte_valid_o <= 1'b0;
      byte_data_o <= 8'h00;
      byte_last_o <= 1'b0;
      cmd_done_o <= 1'b0;
      err_code_o <= `BISR_ERR_OK;
    end else if (ce_i) begin
      cmd_done_o <= 1'b0;
      case (state_r)
        bisr_pkg::BISR_IDLE: begin
          if (cmd_valid_i) begin
            cmd_r <= cmd_code_i;
            idx_r <= 8'h00;
            count_r <= 8'h00;
            kind_r <= bisr_pkg::BISR_KIND_WORD;
            max_r <= 8'h02;
            state_r <= bisr_pkg::BISR_FETCH;
            err_code_o <= `BISR_ERR_OK;
            case (cmd_code_i)
              `BISR_CMD_DESIGN_VOLT: base_r <= `BISR_FLASH_DESIGN_VOLT;
              `BISR_CMD_SPEC_INFO: base_r <= `BISR_FLASH_SPEC_INFO;
              `BISR_CMD_MFG_DATE: base_r <= `BISR_FLASH_MFG_DATE;
              `BISR_CMD_SERIAL: base_r <= `BISR_FLASH_SERIAL;
              `BISR_CMD_PACK_STAT: base_r <= `BISR_FLASH_PACK_CFG;
              `BISR_CMD_MAKER_NAME: begin
                base_r <= `BISR_FLASH_MAKER_LEN;
                max_r <= `BISR_MAKER_MAX;
                kind_r <= bisr_pkg::BISR_KIND_BLOCK;
              end
              `BISR_CMD_DEV_NAME: begin
                base_r <= `BISR_FLASH_DEV_LEN;
                max_r <= `BISR_DEV_MAX;
                kind_r <= bisr_pkg::BISR_KIND_BLOCK;
              end
              `BISR_CMD_CHEMISTRY: begin
                // Chemistry text passes through to the bus; its length byte is clipped to BISR_CHEM_MAX.
                base_r <= `BISR_FLASH_CHEM_LEN;
                max_r <= `BISR_CHEM_MAX;
                kind_r <= bisr_pkg::BISR_KIND_BLOCK;
              end
              `BISR_CMD_MFG_DATA: begin
                base_r <= `BISR_FLASH_PACK_CFG;
                max_r <= `BISR_MFG_DATA_LEN;
                kind_r <= bisr_pkg::BISR_KIND_BLOCK;
              end
              default: begin
                kind_r <= bisr_pkg::BISR_KIND_NONE;
                err_code_o <= `BISR_ERR_UNSUPPORTED;
                cmd_done_o <= 1'b1;
                state_r <= bisr_pkg::BISR_IDLE;
              end
            endcase
            if (cmd_write_i) begin
              // Every code here is read-only.
              err_code_o <= `BISR_ERR_ACCESS_DENIED;
              cmd_done_o <= 1'b1;
              state_r <= bisr_pkg::BISR_IDLE;
            end
          end
        end
        bisr_pkg::BISR_FETCH: begin
          // Flash data for the current address is ready this cycle.
          if (cmd_r == `BISR_CMD_MFG_DATA && idx_r == 8'h00) begin
            pack_cfg_r <= flash_data_i;
          end
          byte_data_o <= send_byte;
          byte_valid_o <= 1'b1;
          if (kind_r == bisr_pkg::BISR_KIND_BLOCK && idx_r == 8'h00) begin
            count_r <= (cmd_r == `BISR_CMD_MFG_DATA) ? 8'h00 : send_byte;
            byte_last_o <= (cmd_r != `BISR_CMD_MFG_DATA)
                           && (send_byte == 8'h00);
          end else if (kind_r == bisr_pkg::BISR_KIND_WORD) begin
            byte_last_o <= (idx_r == 8'h01);
          end else begin
            byte_last_o <= (cmd_r == `BISR_CMD_MFG_DATA)
                           ? (count_r == 8'h0b) : (idx_r == count_r);
          end
          state_r <= bisr_pkg::BISR_SEND;
        end
        bisr_pkg::BISR_SEND: begin
          if (xfer) begin
            byte_valid_o <= 1'b0;
            if (byte_last_o) begin
              byte_last_o <= 1'b0;
              cmd_done_o <= 1'b1;
              state_r <= bisr_pkg::BISR_IDLE;
            end else begin
              idx_r <= idx_r + 8'h01;
              if (cmd_r == `BISR_CMD_MFG_DATA && idx_r != 8'h00) begin
                count_r <= count_r + 8'h01;
              end
              state_r <= bisr_pkg::BISR_FETCH;
            end
          end
        end
        default: state_r <= bisr_pkg::BISR_IDLE;
      endcase
    end
  end

  // Status bit 3 never rises.
  zero_bit_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pack_status_o[`BISR_ST_ZERO] == 1'b0)
    else $error("status bit 3 set");
  // Seal bit follows the sealed level one enabled cycle later.
  seal_bit_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i |=> pack_status_o[`BISR_ST_SEALED] == $past(sealed_i))
    else $error("seal bit wrong");
  // Qualified bit follows its input one enabled cycle later.
  qual_bit_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i |=> pack_status_o[`BISR_ST_QUALIFIED]
    == $past(discharge_qualified_i))
    else $error("qualified bit wrong");
  // Front-end bit passes a holding stage, so it lags by two cycles.
  front_end_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i ##1 ce_i |=>
    pack_status_o[`BISR_ST_FRONT_END] == $past(front_end_check_fail_i, 2))
    else $error("front end bit wrong");
  // End-voltage-two bit tracks the at-or-below test of the chosen voltage.
  edv_bit_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i ##1 ce_i |=> pack_status_o[`BISR_ST_EDV_TWO]
    == ($past(monitored, 2) <= $past(end_voltage_two_i, 2)))
    else $error("end voltage bit wrong");
  // A low top cell raises the undervoltage bit two cycles on.
  cell_uv_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && cell_volts_i[NCELL*16-1 -: 16] < cell_under_limit_i) ##1 ce_i
    |=> pack_status_o[`BISR_ST_CELL_UV])
    else $error("cell under bit missing");
  // A write to any of these codes is refused with no data.
  write_denied_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && state_r == bisr_pkg::BISR_IDLE && cmd_valid_i && cmd_write_i
    |=> cmd_done_o && err_code_o == `BISR_ERR_ACCESS_DENIED
    && !byte_valid_o)
    else $error("write not denied");
  // Start of a block answer: the length byte is being fetched.
  sequence blk_start_s;
    state_r == bisr_pkg::BISR_FETCH && kind_r == bisr_pkg::BISR_KIND_BLOCK
    && idx_r == 8'h00 && ce_i;
  endsequence
  // The length byte never exceeds the string's maximum.
  len_clip_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    blk_start_s |=> byte_valid_o && byte_data_o <= max_r)
    else $error("length above maximum");
  // Manufacturer data always reports twelve bytes.
  mfg_len_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    blk_start_s ##0 (cmd_r == `BISR_CMD_MFG_DATA) |=>
    byte_data_o == `BISR_MFG_DATA_LEN)
    else $error("manufacturer data length wrong");
  // Words fetch their low byte, at the higher flash location, first.
  word_low_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_r == bisr_pkg::BISR_FETCH && kind_r == bisr_pkg::BISR_KIND_WORD
    && cmd_r != `BISR_CMD_PACK_STAT && idx_r == 8'h00
    |-> flash_addr_o == base_r + 8'h01)
    else $error("word not low byte first");
  // A word ends on its second byte.
  word_last_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && state_r == bisr_pkg::BISR_FETCH
    && kind_r == bisr_pkg::BISR_KIND_WORD && idx_r == 8'h01
    |=> byte_valid_o && byte_last_o)
    else $error("word length wrong");
  // Pack status goes out as the low byte of the word.
  pack_low_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && state_r == bisr_pkg::BISR_FETCH
    && cmd_r == `BISR_CMD_PACK_STAT && idx_r == 8'h00
    |=> byte_data_o == $past(pack_status_o))
    else $error("pack status not in low byte");
  // The done pulse follows the accepted last byte.
  last_done_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_r == bisr_pkg::BISR_SEND && xfer && byte_last_o
    |=> cmd_done_o && !byte_valid_o)
    else $error("no done after last byte");
  // A low enable freezes the sender and the status byte.
  ce_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(pack_status_o) && $stable(byte_valid_o)
    && $stable(cmd_done_o))
    else $error("state moved with enable low");
endmodule : bisr_top

// ===== src/bisr_defs.svh
`ifndef BISR_DEFS_SVH
`define BISR_DEFS_SVH
`define BISR_CMD_DESIGN_VOLT 8'h19
`define BISR_CMD_SPEC_INFO 8'h1a
`define BISR_CMD_MFG_DATE 8'h1b
`define BISR_CMD_SERIAL 8'h1c
`define BISR_CMD_MAKER_NAME 8'h20
`define BISR_CMD_DEV_NAME 8'h21
`define BISR_CMD_CHEMISTRY 8'h22
`define BISR_CMD_MFG_DATA 8'h23
`define BISR_CMD_PACK_STAT 8'h2f
`define BISR_FLASH_DESIGN_VOLT 8'h04
`define BISR_FLASH_SPEC_INFO 8'h06
`define BISR_FLASH_MFG_DATE 8'h08
`define BISR_FLASH_SERIAL 8'h0a
`define BISR_FLASH_MAKER_LEN 8'h0e
`define BISR_FLASH_DEV_LEN 8'h1a
`define BISR_FLASH_CHEM_LEN 8'h22
`define BISR_FLASH_PACK_CFG 8'h28
`define BISR_MAKER_MAX 8'h0b
`define BISR_DEV_MAX 8'h07
`define BISR_CHEM_MAX 8'h04
`define BISR_MFG_DATA_LEN 8'h0c
`define BISR_ERR_OK 3'h0
`define BISR_ERR_UNSUPPORTED 3'h3
`define BISR_ERR_ACCESS_DENIED 3'h4
`define BISR_ST_FRONT_END 7
`define BISR_ST_EDV_TWO 6
`define BISR_ST_SEALED 5
`define BISR_ST_QUALIFIED 4
`define BISR_ST_ZERO 3
`define BISR_ST_SAFETY_OV 2
`define BISR_ST_CELL_OV 1
`define BISR_ST_CELL_UV 0
`define BISR_DAY_LSB 0
`define BISR_MONTH_LSB 5
`define BISR_YEAR_LSB 9
`define BISR_YEAR_BASE 1980
`endif

// ===== src/bisr_pkg.sv
package bisr_pkg;
  // Kind of answer a command produces.
  typedef enum logic [1:0] {
    BISR_KIND_NONE,
    BISR_KIND_WORD,
    BISR_KIND_BLOCK
  } bisr_kind_t;
  // Transfer state of the responder.
  typedef enum logic [1:0] {
    BISR_IDLE,
    BISR_FETCH,
    BISR_SEND
  } bisr_state_t;
endpackage : bisr_pkg

// ===== src/bisr_cmp.sv
`timescale 1ns/1ps
// Compares a voltage against a threshold, registered.
module bisr_cmp #(
  parameter int WIDTH = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] value_i,
  input wire logic [WIDTH-1:0] limit_i,
  input wire logic below_only_i,
  output logic hit_o
);
  // Below or equal, or strictly below when asked.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hit_o <= 1'b0;
    end else if (ce_i) begin
      hit_o <= below_only_i ? (value_i < limit_i) : (value_i <= limit_i);
    end
  end
endmodule : bisr_cmp

// ===== tb/bisr_flash_model.sv
`timescale 1ns/1ps
// Data flash seen by the responder: a byte array read combinationally.
module bisr_flash_model (
  input wire logic [7:0] addr_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [256];
  // Unused cells read as the inverted address, so a wrong fetch shows up.
  initial begin
    for (int a = 0; a < 256; a++) mem[a] = ~a[7:0];
    mem[8'h04] = 8'h2a;
    mem[8'h05] = 8'h30;
    mem[8'h06] = 8'h00;
    mem[8'h07] = 8'h31;
    mem[8'h08] = 8'h2c;
    mem[8'h09] = 8'h4f;
    mem[8'h0a] = 8'h00;
    mem[8'h0b] = 8'h01;
    mem[8'h0e] = 8'h0b;
    for (int i = 0; i < 11; i++) mem[8'h0f + i] = 8'h41 + i[7:0];
    // Device name length is above the limit, so the responder must clip it.
    mem[8'h1a] = 8'h09;
    for (int i = 0; i < 7; i++) mem[8'h1b + i] = 8'h61 + i[7:0];
    mem[8'h22] = 8'h04;
    mem[8'h23] = 8'h4c;
    mem[8'h24] = 8'h49;
    mem[8'h25] = 8'h4f;
    mem[8'h26] = 8'h4e;
    mem[8'h28] = 8'hc2;
  end
  // Reads settle in the same cycle as the address.
  assign data_o = mem[addr_i];
endmodule : bisr_flash_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// Host-side bench: issues commands and compares the returned bytes.
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic cmd_write_i = 1'b0;
  logic byte_ready_i = 1'b1;
  logic byte_valid_o, byte_last_o, cmd_done_o;
  logic [7:0] byte_data_o, flash_addr_o, flash_data_i, pack_status_o;
  logic [2:0] err_code_o;
  logic front_end_check_fail_i = 1'b0, sealed_i = 1'b0;
  logic use_cell_voltage_i = 1'b0;
  logic discharge_qualified_i = 1'b0, safety_overvoltage_i = 1'b0;
  logic cell_over_voltage_i = 1'b0;
  logic [15:0] pack_voltage_i = 16'h3000, cell_voltage_i = 16'h3000;
  logic [15:0] end_voltage_two_i = 16'h2800, cell_under_limit_i = 16'h0c00;
  logic [63:0] cell_volts_i = {4{16'h0e00}};
  logic [15:0] near_full_i = 16'h00c8, pending_edv_i = 16'h1234;
  logic [7:0] gauge_cfg_i = 8'h40, misc_cfg_i = 8'h01;
  logic [7:0] digital_filter_i = 8'h22, self_discharge_i = 8'h14;
  logic [7:0] load_estimate_i = 8'h5a, battery_low_i = 8'h12;
  logic [7:0] front_end_status_i = 8'ha5;
  logic slow = 1'b0;
  logic [7:0] got [$];
  logic [7:0] exp [$];
  logic [7:0] wc [4] = '{8'h19, 8'h1a, 8'h1b, 8'h1c};
  logic [15:0] wv [4] = '{16'h2a30, 16'h0031, 16'h2c4f, 16'h0001};
  logic [15:0] date;
  int last_pos;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  bisr_top #(.NCELL(4)) bisr_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_write_i(cmd_write_i), .byte_ready_i(byte_ready_i),
    .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o),
    .byte_last_o(byte_last_o), .cmd_done_o(cmd_done_o),
    .err_code_o(err_code_o), .flash_addr_o(flash_addr_o),
    .flash_data_i(flash_data_i),
    .front_end_check_fail_i(front_end_check_fail_i),
    .pack_voltage_i(pack_voltage_i),
    .cell_voltage_i(cell_voltage_i), .use_cell_voltage_i(use_cell_voltage_i),
    .end_voltage_two_i(end_voltage_two_i), .cell_volts_i(cell_volts_i),
    .cell_under_limit_i(cell_under_limit_i), .sealed_i(sealed_i),
    .discharge_qualified_i(discharge_qualified_i),
    .safety_overvoltage_i(safety_overvoltage_i),
    .cell_over_voltage_i(cell_over_voltage_i), .gauge_cfg_i(gauge_cfg_i),
    .misc_cfg_i(misc_cfg_i), .digital_filter_i(digital_filter_i),
    .self_discharge_i(self_discharge_i), .load_estimate_i(load_estimate_i),
    .battery_low_i(battery_low_i), .near_full_i(near_full_i),
    .front_end_status_i(front_end_status_i), .pending_edv_i(pending_edv_i),
    .pack_status_o(pack_status_o));

  bisr_flash_model bisr_flash_model_i (.addr_i(flash_addr_o),
    .data_o(flash_data_i));

  // Free-running clock, 10 ns period.
  always #5 mclk_i = ~mclk_i;

  // The host accepts every cycle, or every other cycle when slow.
  always @(posedge mclk_i) byte_ready_i <= slow ? ~byte_ready_i : 1'b1;

  // A hung run is cut short and reported as failed.
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Counts one comparison and reports it when the values differ.
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  // Issues one command and gathers the bytes until the done pulse.
  task automatic run_cmd(input logic [7:0] code, input logic wr);
    int n;
    got.delete();
    last_pos = -1;
    n = 0;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i <= code;
    cmd_write_i <= wr;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    #1;
    while (cmd_done_o !== 1'b1 && n < 200) begin
      if (byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
        if (byte_last_o === 1'b1) last_pos = got.size();
        got.push_back(byte_data_o);
      end
      @(posedge mclk_i);
      #1;
      n++;
    end
    check({15'h0000, cmd_done_o}, 16'h0001);
  endtask : run_cmd

  // Compares error code, byte stream and the position of the last marker.
  task automatic cmp_bytes(input logic [2:0] err);
    check({13'h0000, err_code_o}, {13'h0000, err});
    check(16'(got.size()), 16'(exp.size()));
    for (int i = 0; i < exp.size(); i++) begin
      check({8'h00, got[i]}, {8'h00, exp[i]});
    end
    if (exp.size() > 0) check(16'(last_pos), 16'(exp.size() - 1));
  endtask : cmp_bytes

  // Lets the status flags settle, then reads them on the pin and the bus.
  task automatic status_case(input logic [7:0] want);
    repeat (6) @(posedge mclk_i);
    #1;
    check({8'h00, pack_status_o}, {8'h00, want});
    exp = {want, 8'hc2};
    run_cmd(8'h2f, 1'b0);
    cmp_bytes(3'h0);
  endtask : status_case

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Main sequence: words, blocks, status flags, then refused requests.
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      exp = {wv[i][7:0], wv[i][15:8]};
      run_cmd(wc[i], 1'b0);
      cmp_bytes(3'h0);
      if (i == 2) begin
        date = {got[1], got[0]};
        check({11'h000, date[4:0]}, 16'h000f);
        check({12'h000, date[8:5]}, 16'h0002);
        check(16'(date[15:9]) + 16'd1980, 16'd2002);
      end
    end
    $display("test words done");
    slow <= 1'b1;
    exp = {8'h0b};
    for (int i = 0; i < 11; i++) exp.push_back(8'h41 + i[7:0]);
    run_cmd(8'h20, 1'b0);
    cmp_bytes(3'h0);
    exp = {8'h07};
    for (int i = 0; i < 7; i++) exp.push_back(8'h61 + i[7:0]);
    run_cmd(8'h21, 1'b0);
    cmp_bytes(3'h0);
    exp = {8'h04, 8'h4c, 8'h49, 8'h4f, 8'h4e};
    run_cmd(8'h22, 1'b0);
    cmp_bytes(3'h0);
    exp = {8'h0c, 8'hc2, 8'h40, 8'h01, 8'h22, 8'h14, 8'h5a, 8'h12, 8'hc8,
      8'h00, 8'ha5, 8'h34, 8'h12};
    run_cmd(8'h23, 1'b0);
    cmp_bytes(3'h0);
    slow <= 1'b0;
    $display("test blocks done");
    status_case(8'h00);
    @(posedge mclk_i);
    front_end_check_fail_i <= 1'b1;
    pack_voltage_i <= 16'h2800;
    sealed_i <= 1'b1;
    safety_overvoltage_i <= 1'b1;
    cell_volts_i <= {{3{16'h0e00}}, 16'h0c00};
    status_case(8'he4);
    @(posedge mclk_i);
    front_end_check_fail_i <= 1'b0;
    sealed_i <= 1'b0;
    safety_overvoltage_i <= 1'b0;
    discharge_qualified_i <= 1'b1;
    cell_over_voltage_i <= 1'b1;
    use_cell_voltage_i <= 1'b1;
    cell_voltage_i <= 16'h2801;
    cell_volts_i <= {16'h0bff, 16'h0e00, 16'h0e00, 16'h0c00};
    status_case(8'h13);
    // With the enable low the status byte must not follow the seal input.
    @(posedge mclk_i);
    ce_i <= 1'b0;
    sealed_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    check({8'h00, pack_status_o}, 16'h0013);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    status_case(8'h33);
    $display("test status done");
    exp.delete();
    run_cmd(8'h19, 1'b1);
    cmp_bytes(3'h4);
    run_cmd(8'h2f, 1'b1);
    cmp_bytes(3'h4);
    run_cmd(8'h30, 1'b0);
    cmp_bytes(3'h3);
    $display("test refusals done");
    give_verdict();
  end
endmodule : tb_top
